// File: common/epc_consts.vh
/*
 * Constants of the parameter-channel command interpreter: command bytes,
 * status codes, factory defaults and field widths.
 * Assumes inclusion by bare name from design files; holds definitions only.
 */
`ifndef EPC_CONSTS_VH
`define EPC_CONSTS_VH

// Command bytes.
`define EPC_CMD_RD_POS      8'h42
`define EPC_CMD_SET_POS     8'h43
`define EPC_CMD_RD_ANALOG   8'h44
`define EPC_CMD_RD_CNT      8'h46
`define EPC_CMD_INC_CNT     8'h47
`define EPC_CMD_DEL_CNT     8'h49
`define EPC_CMD_RD_DATA     8'h4a
`define EPC_CMD_ST_DATA     8'h4b
`define EPC_CMD_FLD_STAT    8'h4c
`define EPC_CMD_MK_FIELD    8'h4d
`define EPC_CMD_MEM_FREE    8'h4e
`define EPC_CMD_CHG_CODE    8'h4f
`define EPC_CMD_RD_STATUS   8'h50
`define EPC_CMD_RD_TYPE     8'h52
`define EPC_CMD_RESET       8'h53
`define EPC_CMD_SET_ADDR    8'h55
`define EPC_CMD_RD_SERIAL   8'h56
`define EPC_CMD_CFG_IF      8'h57

// Status codes.
`define EPC_ST_OK           8'h00
`define EPC_ST_WATCHDOG     8'h07
`define EPC_ST_CNT_OVF      8'h08
`define EPC_ST_PARITY       8'h09
`define EPC_ST_CHECKSUM     8'h0a
`define EPC_ST_UNK_CMD      8'h0b
`define EPC_ST_BAD_LEN      8'h0c
`define EPC_ST_BAD_ARG      8'h0d
`define EPC_ST_WR_PROT      8'h0e
`define EPC_ST_BAD_CODE     8'h0f
`define EPC_ST_SIZE_FIXED   8'h10
`define EPC_ST_ADDR_RANGE   8'h11
`define EPC_ST_NO_FIELD     8'h12
`define EPC_ST_ANA_MON      8'h1c
`define EPC_ST_CUR_RAM      8'h1d
`define EPC_ST_TEMP         8'h1e
`define EPC_ST_SPEED        8'h1f
`define EPC_ST_ST_UNREL     8'h20
`define EPC_ST_MT_ERR0      8'h21
`define EPC_ST_INIT0        8'h01

// Bit positions inside the synchronised fault vector.
`define EPC_FB_TEMP         1
`define EPC_FB_CUR          2
`define EPC_FB_ANA          3
`define EPC_FB_MT           4
`define EPC_FB_STU          7
`define EPC_FB_SPD          8
`define EPC_FB_WDG          9
`define EPC_FB_INIT         10

// Factory defaults.
`define EPC_DEF_ADDR        8'h40
`define EPC_DEF_IFCFG       8'he4
`define EPC_DEF_CODE        8'h55
`define EPC_DEF_CNT         16'h0000
`define EPC_CNT_MAX         16'hffff
`define EPC_MODEL_CODE      8'h5a

// Widths and expected data-byte counts per command.
`define EPC_POS_W           27
`define EPC_POS_ZERO        27'h0000000
`define EPC_NB_ZERO         4'h0
`define EPC_NB_ONE          4'h1
`define EPC_NB_SETPOS       4'h5
`define EPC_INIT_W          6
`define EPC_MT_W            3
`define EPC_CODE_IDX_W      2
`define EPC_CODE_CODE0      2'h0
`define EPC_CODES           4

`endif

// File: rtl/epc_code_mem.v
/*
 * Small memory holding the four access codes, loaded with factory values.
 * Assumes one clock, synchronous active-high reset; read data are registered.
 */
`timescale 1ns/100ps
`include "epc_consts.vh"

module epc_code_mem (
    // Clock and reset.
    input  wire        clk_sys,
    input  wire        rst,
    // Write port.
    input  wire        wr_en,
    input  wire [1:0]  wr_idx,
    input  wire [7:0]  wr_data,
    // Read port.
    input  wire [1:0]  rd_idx,
    output reg  [7:0]  rd_data_q
);

    reg [7:0] mem_q [0:`EPC_CODES-1];
    genvar gi;

    // Each code slot returns to its factory value on reset.
    generate
        for (gi = 0; gi < `EPC_CODES; gi = gi + 1) begin : g_slot
            always @(posedge clk_sys) begin
                if (rst) begin
                    mem_q[gi] <= `EPC_DEF_CODE;
                end else if (wr_en && (wr_idx == gi)) begin
                    mem_q[gi] <= wr_data;
                end
            end
        end
    endgenerate

    // Registered read keeps the compare path in the caller short.
    always @(posedge clk_sys) begin
        if (rst) begin
            rd_data_q <= `EPC_DEF_CODE;
        end else begin
            rd_data_q <= mem_q[rd_idx];
        end
    end

endmodule

// File: rtl/epc_interp.v
/*
 * Parameter-channel command interpreter of an absolute feedback encoder.
 * Assumes a framer has already assembled command frames: one cmd_valid pulse
 * carries command byte, argument bytes, data-byte count and framing flags.
 * All inputs come from logic on clk_sys except the fault levels, which are
 * synchronised here.
 */
// Contract
// - Status reads 00h while no fault has been seen since clearance.
// - Initialization faults report codes 01h to 06h.
// - A watchdog-forced reset is flagged afterwards with 07h.
// - Frame errors report 09h parity, 0Ah checksum, 0Bh command, 0Ch count, 0Dh argument.
// - Data-area errors report 0Eh to 12h.
// - Overspeed 1Fh, unreliable singleturn 20h, multiturn errors 21h to 23h.
// - Monitoring reports 1Ch, 1Dh, 1Eh, and counter overflow 08h.
// - Accept 42h,43h,44h,46h,47h,49h; 42h gives 27-bit position; 49h needs code.
// - Type label 52h returns model code; defaults address 40h, config E4h, codes 55h, counter 0.
// - Protected commands carry an access byte; a mismatch refuses the command.
// - Also accept 4Ah-4Fh, 50h, 53h, 55h, 56h and 57h.
`timescale 1ns/100ps
`include "epc_consts.vh"

module epc_interp (
    // Clock and reset.
    input  wire        clk_sys,
    input  wire        rst,
    // Decoded frame from the framer.
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_byte,
    input  wire [7:0]  cmd_arg0,
    input  wire [7:0]  cmd_arg1,
    input  wire [3:0]  cmd_nbytes,
    input  wire        frame_parity_err,
    input  wire        frame_chk_err,
    // Data-area outcome reported by the memory manager.
    input  wire        data_wr_prot,
    input  wire        data_size_fixed,
    input  wire        data_addr_range,
    input  wire        data_no_field,
    // Fault levels from the sensing logic, and the status clear.
    input  wire [5:0]  init_fault,
    input  wire        wdog_reset_seen,
    input  wire        overspeed,
    input  wire        st_unreliable,
    input  wire [2:0]  mt_fault,
    input  wire        ana_mon_fault,
    input  wire        cur_ram_fault,
    input  wire        temp_fault,
    input  wire        err_clear,
    // Live position.
    input  wire [26:0] position_in,
    // Reply.
    output reg         rsp_valid_q,
    output reg  [7:0]  rsp_cmd_q,
    output reg  [31:0] rsp_data_q,
    output reg         rsp_err_q,
    // Held settings and state.
    output reg  [7:0]  status_q,
    output reg  [7:0]  bus_addr_q,
    output reg  [7:0]  if_cfg_q,
    output reg  [15:0] counter_q,
    output reg  [26:0] pos_offset_q,
    output reg         enc_reset_q
);

    // Known command test, used only for the unknown-command check in decode.
    function is_known;
        input [7:0] c;
        begin
            case (c)
                `EPC_CMD_RD_POS, `EPC_CMD_SET_POS, `EPC_CMD_RD_ANALOG, `EPC_CMD_RD_CNT,
                `EPC_CMD_INC_CNT, `EPC_CMD_DEL_CNT,
                `EPC_CMD_RD_DATA, `EPC_CMD_ST_DATA, `EPC_CMD_FLD_STAT, `EPC_CMD_MK_FIELD,
                `EPC_CMD_MEM_FREE, `EPC_CMD_CHG_CODE, `EPC_CMD_RD_STATUS, `EPC_CMD_RD_TYPE,
                `EPC_CMD_RESET, `EPC_CMD_SET_ADDR, `EPC_CMD_RD_SERIAL, `EPC_CMD_CFG_IF: is_known = 1'b1;
                default: is_known = 1'b0;
            endcase
        end
    endfunction

    // Commands that carry the protection byte in arg0.
    function is_protected;
        input [7:0] c;
        begin
            is_protected = (c == `EPC_CMD_DEL_CNT) || (c == `EPC_CMD_CHG_CODE) ||
                           (c == `EPC_CMD_SET_ADDR) || (c == `EPC_CMD_CFG_IF);
        end
    endfunction

    // Fault levels pass two flops; only the second stage is read.
    reg [15:0] flt_s1_q;
    reg [15:0] flt_s2_q;
    wire [15:0] flt_raw = {init_fault, wdog_reset_seen, overspeed, st_unreliable,
                           mt_fault, ana_mon_fault, cur_ram_fault, temp_fault, 1'b0};
    always @(posedge clk_sys) begin
        if (rst) begin
            flt_s1_q <= 16'h0000;
            flt_s2_q <= 16'h0000;
        end else begin
            flt_s1_q <= flt_raw;
            flt_s2_q <= flt_s1_q;
        end
    end

    // A rising edge of a fault level reports once, unless a refused frame, an overflow or a lower-coded edge takes the same cycle.
    reg  [15:0] flt_old_q;
    wire [15:0] flt_rise = flt_s2_q & ~flt_old_q;

    // Access code memory; code 0 is the one protected commands compare against.
    wire [7:0] code0;
    wire       code_wr;
    epc_code_mem u_codes (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .wr_en     (code_wr),
        .wr_idx    (cmd_arg1[1:0]),
        .wr_data   (cmd_arg1),
        .rd_idx    (`EPC_CODE_CODE0),
        .rd_data_q (code0)
    );

    // Frame checks in priority order: framing, command, count, argument, code.
    wire known     = is_known(cmd_byte);
    reg  [3:0] need_nb;
    always @* begin
        case (cmd_byte)
            `EPC_CMD_SET_POS: need_nb = `EPC_NB_SETPOS;
            `EPC_CMD_RD_ANALOG, `EPC_CMD_DEL_CNT, `EPC_CMD_SET_ADDR, `EPC_CMD_CFG_IF: need_nb = `EPC_NB_ONE;
            `EPC_CMD_CHG_CODE: need_nb = `EPC_NB_ONE + `EPC_NB_ONE;
            default: need_nb = `EPC_NB_ZERO;
        endcase
    end
    // Data-area commands carry a variable count, so the framer's count is trusted there.
    wire var_len = (cmd_byte >= `EPC_CMD_RD_DATA) && (cmd_byte <= `EPC_CMD_MEM_FREE);
    wire len_ok  = var_len || (cmd_nbytes == need_nb);
    wire arg_ok  = !(cmd_byte == `EPC_CMD_SET_ADDR && cmd_arg1 == 8'h00);
    wire code_ok = !is_protected(cmd_byte) || (cmd_arg0 == code0);

    reg [7:0] frame_code;
    always @* begin
        if (frame_parity_err)       frame_code = `EPC_ST_PARITY;
        else if (frame_chk_err)     frame_code = `EPC_ST_CHECKSUM;
        else if (!known)            frame_code = `EPC_ST_UNK_CMD;
        else if (!len_ok)           frame_code = `EPC_ST_BAD_LEN;
        else if (!arg_ok)           frame_code = `EPC_ST_BAD_ARG;
        else if (!code_ok)          frame_code = `EPC_ST_BAD_CODE;
        else if (data_wr_prot)      frame_code = `EPC_ST_WR_PROT;
        else if (data_size_fixed)   frame_code = `EPC_ST_SIZE_FIXED;
        else if (data_addr_range)   frame_code = `EPC_ST_ADDR_RANGE;
        else if (data_no_field)     frame_code = `EPC_ST_NO_FIELD;
        else                        frame_code = `EPC_ST_OK;
    end
    wire cmd_ok = cmd_valid && (frame_code == `EPC_ST_OK);
    wire ovf    = cmd_ok && (cmd_byte == `EPC_CMD_INC_CNT) && (counter_q == `EPC_CNT_MAX);
    // Only an accepted code change writes, so a refused frame leaves every code untouched.
    assign code_wr = cmd_ok && (cmd_byte == `EPC_CMD_CHG_CODE);

    // Fault code from sensed conditions, lowest-numbered class first.
    reg [7:0] sense_code;
    integer i;
    always @* begin
        sense_code = `EPC_ST_OK;
        // Highest codes are written first so that the lowest code is left standing.
        for (i = `EPC_MT_W - 1; i >= 0; i = i - 1) begin
            if (flt_rise[`EPC_FB_MT + i]) sense_code = `EPC_ST_MT_ERR0 + i[7:0];
        end
        if (flt_rise[`EPC_FB_STU])  sense_code = `EPC_ST_ST_UNREL;
        if (flt_rise[`EPC_FB_SPD])  sense_code = `EPC_ST_SPEED;
        if (flt_rise[`EPC_FB_TEMP]) sense_code = `EPC_ST_TEMP;
        if (flt_rise[`EPC_FB_CUR])  sense_code = `EPC_ST_CUR_RAM;
        if (flt_rise[`EPC_FB_ANA])  sense_code = `EPC_ST_ANA_MON;
        if (flt_rise[`EPC_FB_WDG])  sense_code = `EPC_ST_WATCHDOG;
        for (i = `EPC_INIT_W - 1; i >= 0; i = i - 1) begin
            if (flt_rise[`EPC_FB_INIT + i]) sense_code = `EPC_ST_INIT0 + i[7:0];
        end
    end

    // Status holds the latest fault; a new fault in the clear cycle wins.
    reg [7:0] new_code;
    always @* begin
        if (cmd_valid && frame_code != `EPC_ST_OK) new_code = frame_code;
        else if (ovf)                              new_code = `EPC_ST_CNT_OVF;
        else                                       new_code = sense_code;
    end
    always @(posedge clk_sys) begin
        if (rst) begin
            status_q  <= `EPC_ST_OK;
            flt_old_q <= 16'h0000;
        end else begin
            flt_old_q <= flt_s2_q;
            if (new_code != `EPC_ST_OK) begin
                status_q <= new_code;
            end else if (err_clear || (cmd_ok && cmd_byte == `EPC_CMD_RESET)) begin
                status_q <= `EPC_ST_OK;
            end
        end
    end

    // Command execution and reply; settings start at factory values.
    always @(posedge clk_sys) begin
        if (rst) begin
            rsp_valid_q  <= 1'b0;
            rsp_cmd_q    <= 8'h00;
            rsp_data_q   <= 32'h00000000;
            rsp_err_q    <= 1'b0;
            bus_addr_q   <= `EPC_DEF_ADDR;
            if_cfg_q     <= `EPC_DEF_IFCFG;
            counter_q    <= `EPC_DEF_CNT;
            pos_offset_q <= `EPC_POS_ZERO;
            enc_reset_q  <= 1'b0;
        end else begin
            rsp_valid_q <= cmd_valid;
            rsp_cmd_q   <= cmd_valid ? cmd_byte : rsp_cmd_q;
            rsp_err_q   <= cmd_valid && !cmd_ok;
            enc_reset_q <= cmd_ok && (cmd_byte == `EPC_CMD_RESET);
            if (cmd_valid) begin
                rsp_data_q <= {24'h000000, frame_code};
            end
            if (cmd_ok) begin
                case (cmd_byte)
                    `EPC_CMD_RD_POS:    rsp_data_q <= {5'h00, position_in + pos_offset_q};
                    `EPC_CMD_SET_POS:   pos_offset_q <= {cmd_arg1[2:0], 24'h000000} - position_in;
                    `EPC_CMD_RD_ANALOG: rsp_data_q <= {24'h000000, cmd_arg0};
                    `EPC_CMD_RD_CNT:    rsp_data_q <= {16'h0000, counter_q};
                    `EPC_CMD_INC_CNT: begin
                        if (counter_q != `EPC_CNT_MAX) counter_q <= counter_q + 16'h0001;
                        rsp_data_q <= {16'h0000, counter_q};
                    end
                    `EPC_CMD_DEL_CNT:   counter_q <= `EPC_DEF_CNT;
                    `EPC_CMD_RD_STATUS: rsp_data_q <= {24'h000000, status_q};
                    `EPC_CMD_RD_TYPE:   rsp_data_q <= {24'h000000, `EPC_MODEL_CODE};
                    `EPC_CMD_SET_ADDR:  bus_addr_q <= cmd_arg1;
                    `EPC_CMD_CFG_IF:    if_cfg_q <= cmd_arg1;
                    default:            rsp_data_q <= {24'h000000, `EPC_ST_OK};
                endcase
            end
        end
    end

endmodule

// File: test/epc_monitor.sv
/* Checker for the parameter-channel interpreter, bound to its top module.
   Assumes one clock domain and the synchronous active-high reset rst. */
`timescale 1ns/100ps
`include "epc_consts.vh"
module epc_monitor (
    // Clock and reset.
    input wire logic        clk_sys,
    input wire logic        rst,
    // Frame inputs.
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_byte,
    input wire logic [3:0]  cmd_nbytes,
    input wire logic        frame_parity_err,
    input wire logic        frame_chk_err,
    // Reply and held state.
    input wire logic        rsp_valid_q,
    input wire logic [7:0]  rsp_cmd_q,
    input wire logic [31:0] rsp_data_q,
    input wire logic        rsp_err_q,
    input wire logic [7:0]  bus_addr_q,
    input wire logic [15:0] counter_q,
    input wire logic        enc_reset_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // A clean frame is one with no framing flag raised.
    wire clean = cmd_valid && !frame_parity_err && !frame_chk_err;
    a_rsp_follows: assert property (cmd_valid |=> rsp_valid_q && rsp_cmd_q == $past(cmd_byte))
        else $error("reply missing or wrong command echo");
    a_no_idle_rsp: assert property (!cmd_valid |=> !rsp_valid_q)
        else $error("reply without a frame");
    a_parity_code: assert property (cmd_valid && frame_parity_err |=> rsp_err_q && rsp_data_q[7:0] == 8'h09)
        else $error("parity fault code wrong");
    a_chk_code: assert property (cmd_valid && !frame_parity_err && frame_chk_err |=> rsp_err_q ##0 rsp_data_q[7:0] == 8'h0a)
        else $error("checksum fault code wrong");
    a_unknown_cmd: assert property (clean && cmd_byte == 8'h41 |=> rsp_err_q && rsp_data_q[7:0] == 8'h0b)
        else $error("unknown command not refused");
    a_type_label: assert property (clean && cmd_byte == 8'h52 && cmd_nbytes == 4'h0 |=> !rsp_err_q && rsp_data_q[7:0] == `EPC_MODEL_CODE)
        else $error("type label wrong");
    a_addr_stable: assert property (!(cmd_valid && cmd_byte == 8'h55) |=> $stable(bus_addr_q))
        else $error("address changed without command");
    a_cnt_inc: assert property (clean && cmd_byte == 8'h47 && cmd_nbytes == 4'h0 && counter_q != 16'hffff
        |=> counter_q == $past(counter_q) + 16'h0001)
        else $error("counter did not step");
    a_reset_pulse: assert property (enc_reset_q |=> !enc_reset_q)
        else $error("encoder reset pulse too long");
    a_err_has_valid: assert property (rsp_err_q |-> rsp_valid_q)
        else $error("refusal flag without reply");
    c_parity: cover property (cmd_valid && frame_parity_err);
    c_enc_reset: cover property (enc_reset_q);
    c_bad_code: cover property (rsp_err_q && rsp_data_q[7:0] == 8'h0f);
endmodule

// File: test/epc_ctrl_model.sv
/* Drive-controller model: issues whole decoded frames, one per call.
   Assumes a free-running clk_sys; outputs change on falling edges only. */
`timescale 1ns/100ps
module epc_ctrl_model (
    // Clock.
    input wire logic  clk_sys,
    // Frame towards the interpreter.
    output logic       cmd_valid,
    output logic [7:0] cmd_byte,
    output logic [7:0] cmd_arg0,
    output logic [7:0] cmd_arg1,
    output logic [3:0] cmd_nbytes,
    output logic       frame_parity_err,
    output logic       frame_chk_err
);
    // Idle fields start at zero and later carry inverted bytes, so a stale frame never looks valid by chance.
    initial {cmd_valid, cmd_byte, cmd_arg0, cmd_arg1, cmd_nbytes, frame_parity_err, frame_chk_err} = '0;
    // One frame per call; the protection byte travels in arg0.
    task automatic send(input logic [7:0] c, a0, a1, input logic [3:0] nb, input logic pe, ce);
        @(negedge clk_sys);
        {cmd_valid, cmd_byte, cmd_arg0, cmd_arg1, cmd_nbytes, frame_parity_err, frame_chk_err} = {1'b1, c, a0, a1, nb, pe, ce};
        @(negedge clk_sys);
        {cmd_valid, cmd_byte, cmd_arg0, cmd_arg1, cmd_nbytes, frame_parity_err, frame_chk_err} = {1'b0, ~c, ~a0, ~a1, ~nb, 2'b00};
    endtask
endmodule

// File: test/tb.sv
/* Self-checking bench for the parameter-channel interpreter.
   Assumes the controller model in epc_ctrl_model and the checker in epc_monitor. */
`timescale 1ns/100ps
`include "epc_consts.vh"
module tb;
    // Clock, reset, frame and fault wires.
    logic clk_sys = 1'b0, rst = 1'b1, err_clear = 1'b0;
    logic data_wr_prot = 1'b0, data_size_fixed = 1'b0, data_addr_range = 1'b0, data_no_field = 1'b0;
    logic [14:0] flt = '0;
    logic [26:0] position_in = '0;
    wire cmd_valid, frame_parity_err, frame_chk_err, rsp_valid_q, rsp_err_q, enc_reset_q;
    wire [7:0] cmd_byte, cmd_arg0, cmd_arg1, rsp_cmd_q, status_q, bus_addr_q, if_cfg_q;
    wire [3:0] cmd_nbytes;
    wire [31:0] rsp_data_q;
    wire [15:0] counter_q;
    wire [26:0] pos_offset_q;
    wire [5:0] init_fault = flt[5:0];
    wire [2:0] mt_fault = flt[11:9];
    wire wdog_reset_seen = flt[6], overspeed = flt[7], st_unreliable = flt[8];
    wire ana_mon_fault = flt[12], cur_ram_fault = flt[13], temp_fault = flt[14];
    integer num_errors = 0, n_checks = 0, seed = 34451, k;
    logic [72:0] expq[$];
    logic [7:0] v;
    always #20 clk_sys = ~clk_sys;
    epc_ctrl_model u_ctrl (.*);
    epc_interp i_epc_interp (.*);
    task automatic fail(input string m);
        num_errors++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic cmp_val(input logic [31:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) fail(m);
    endtask
    task automatic cmp_rsp(input logic [72:0] x);
        n_checks++;
        if ({rsp_err_q, rsp_cmd_q, rsp_data_q & x[31:0]} !== x[72:32]) fail("reply mismatch");
    endtask
    // Note the expected reply first, so the watcher can never see a reply ahead of its note.
    task automatic op(input logic [7:0] c, a0, a1, input logic [3:0] nb, input logic pe, ce, er,
                      input logic [31:0] d, m);
        expq.push_back({er, c, d & m, m});
        u_ctrl.send(c, a0, a1, nb, pe, ce);
    endtask
    task automatic clear_status;
        err_clear = 1'b1;
        @(negedge clk_sys);
        err_clear = 1'b0;
        @(negedge clk_sys);
        cmp_val(status_q, 8'h00, "status not cleared");
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic [7:0] fcode(input integer i);
        fcode = 8'(i < 6 ? i + 1 : i == 6 ? 8'h07 : i == 7 ? 8'h1f : i == 8 ? 8'h20 : i < 12 ? 8'h21 + i - 9 : 8'h1c + i - 12);
    endfunction
    // Replies are matched in order against the oldest note.
    always @(negedge clk_sys) begin
        if (rsp_valid_q === 1'b1) begin
            if (expq.size() == 0) fail("unexpected reply");
            else cmp_rsp(expq.pop_front());
        end
    end
    // A hang anywhere ends the run as a failure.
    initial begin
        #800000;
        fail("timeout");
        summarize();
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        cmp_val({bus_addr_q, if_cfg_q, counter_q}, 32'h40e40000, "defaults wrong");
        cmp_val(status_q, 8'h00, "status not idle");
        position_in = 27'($random(seed));
        op(8'h42, 0, 0, 0, 0, 0, 0, position_in, 32'h07ffffff);
        op(8'h52, 0, 0, 0, 0, 0, 0, `EPC_MODEL_CODE, 32'hff);
        op(8'h44, 8'h48, 0, 1, 0, 0, 0, 8'h48, 32'hff);
        op(8'h43, 0, 8'h05, 5, 0, 0, 0, 0, 0);
        cmp_val(pos_offset_q, 27'({3'h5, 24'h0} - position_in), "offset wrong");
        op(8'h42, 0, 0, 0, 0, 0, 0, {5'h0, 3'h5, 24'h0}, 32'h07ffffff);
        $display("position tests done");
        op(8'h42, 0, 0, 0, 1, 0, 1, 8'h09, 32'hff);
        op(8'h42, 0, 0, 0, 0, 1, 1, 8'h0a, 32'hff);
        op(8'h41, 0, 0, 0, 0, 0, 1, 8'h0b, 32'hff);
        op(8'h42, 0, 0, 1, 0, 0, 1, 8'h0c, 32'hff);
        op(8'h55, 8'h55, 0, 1, 0, 0, 1, 8'h0d, 32'hff);
        op(8'h50, 0, 0, 0, 0, 0, 0, 8'h0d, 32'hff);
        cmp_val(status_q, 8'h0d, "status not held");
        clear_status();
        for (k = 0; k < 4; k++) begin
            {data_wr_prot, data_size_fixed, data_addr_range, data_no_field} = 4'b1000 >> k;
            op(8'h4a, 0, 0, 0, 0, 0, 1, k == 0 ? 8'h0e : 8'h10 + k - 1, 32'hff);
            {data_wr_prot, data_size_fixed, data_addr_range, data_no_field} = 4'b0000;
        end
        clear_status();
        $display("refusal tests done");
        op(8'h47, 0, 0, 0, 0, 0, 0, 0, 0);
        op(8'h46, 0, 0, 0, 0, 0, 0, 1, 32'hffff);
        op(8'h49, 8'h12, 0, 1, 0, 0, 1, 8'h0f, 32'hff);
        cmp_val(counter_q, 16'h0001, "counter wrong");
        op(8'h49, 8'h55, 0, 1, 0, 0, 0, 0, 0);
        cmp_val(counter_q, 16'h0000, "counter not deleted");
        v = 8'($random(seed)) | 8'h01;
        op(8'h55, 8'h55, v, 1, 0, 0, 0, 0, 0);
        op(8'h57, 8'h55, ~v, 1, 0, 0, 0, 0, 0);
        cmp_val({bus_addr_q, if_cfg_q}, {v, ~v}, "address or config wrong");
        op(8'h4f, 8'h55, 8'ha4, 2, 0, 0, 0, 0, 0);
        op(8'h49, 8'h55, 0, 1, 0, 0, 1, 8'h0f, 32'hff);
        op(8'h49, 8'ha4, 0, 1, 0, 0, 0, 0, 0);
        op(8'h53, 0, 0, 0, 0, 0, 0, 0, 0);
        cmp_val(enc_reset_q, 1, "encoder reset missing");
        cmp_val(status_q, 8'h00, "reset left status");
        $display("command tests done");
        for (k = 0; k < 15; k++) begin
            flt = 15'(1 << k);
            repeat (5) @(negedge clk_sys);
            cmp_val(status_q, fcode(k), "fault code wrong");
            flt = '0;
            clear_status();
        end
        $display("fault tests done");
        for (k = 0; k < 20 && expq.size() != 0; k++) @(negedge clk_sys);
        if (expq.size() != 0) fail("replies missing");
        summarize();
    end
endmodule
bind epc_interp epc_monitor i_epc_monitor (.*);
